// ==== design/eba_aligner.v ====
/*
 External bus endian aligner: takes byte, word and longword requests
 from an internal master and runs them as one or more external byte
 or word cycles with the lane placement of the addressed area.
 Assumes an external cycle engine that answers each cycle with a
 one-cycle extReady and returns read lanes in that same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eba_regs.vh"

module eba_aligner
(
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Area configuration
    input wire [7:0] areaWide16,
    input wire [7:0] areaLittleOrderSelect,
    // Internal request
    input wire reqValid,
    output reg reqReady,
    input wire reqWrite,
    input wire [1:0] reqSize,
    input wire [2:0] reqArea,
    input wire [23:0] reqAddr,
    input wire [31:0] reqWData,
    // Internal answer
    output reg rspValid,
    output reg [31:0] rspRData,
    // External cycle
    output reg extValid,
    input wire extReady,
    output reg extWrite,
    output reg extWord,
    output reg [23:0] extAddr,
    output reg extUpperEn,
    output reg extLowerEn,
    output reg [15:0] extWData,
    input wire [15:0] extRData
);

    // ****************************************
    // Request hold and sequencing state
    // ****************************************
    reg state_ff;
    reg wide_ff;
    reg little_ff;
    reg write_ff;
    reg [1:0] size_ff;
    reg [23:0] addr_ff;
    reg [31:0] wdata_ff;
    reg [1:0] off_ff;
    reg last_ff;
    reg [1:0] upIdx_ff;
    reg [1:0] loIdx_ff;
    reg [31:0] asm_ff;
    reg [7:0] order_ff;

    localparam [0:0] ST_IDLE = 1'b0;
    localparam [0:0] ST_BUSY = 1'b1;

    wire take = (state_ff == ST_IDLE) && reqValid;
    wire adv = (state_ff == ST_BUSY) && extReady;
    wire mapWide;
    wire mapLittle;
    wire [1:0] mapSize;
    wire mapAddr0;
    wire [1:0] mapOff;
    wire mWord;
    wire [1:0] mUpIdx;
    wire [1:0] mLoIdx;
    wire mUpEn;
    wire mLoEn;
    wire mLast;
    wire [31:0] mapWData;
    wire [23:0] mapAddr;
    wire [31:0] nxt_asm;

    // Registered every cycle, so a change needs one cycle before a request
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            order_ff <= `EBA_ORDER_RESET;
        else
            order_ff <= areaLittleOrderSelect;
    end

    // ****************************************
    // Plan next cycle from new request or held one
    // ****************************************
    assign mapWide = take ? areaWide16[reqArea] : wide_ff;
    assign mapLittle = take ? order_ff[reqArea] : little_ff;
    assign mapSize = take ? reqSize : size_ff;
    assign mapAddr = take ? reqAddr : addr_ff;
    assign mapAddr0 = mapAddr[0];
    assign mapWData = take ? reqWData : wdata_ff;
    // Next offset skips two bytes after a word cycle
    assign mapOff = take ? 2'h0 : off_ff + (extWord ? 2'h2 : 2'h1);

    eba_lane_map u_map
    (
        .wide(mapWide),
        .little(mapLittle),
        .size(mapSize),
        .addr0(mapAddr0),
        .off(mapOff),
        .wordCyc(mWord),
        .upIdx(mUpIdx),
        .loIdx(mLoIdx),
        .upEn(mUpEn),
        .loEn(mLoEn),
        .last(mLast)
    );

    // ****************************************
    // Read reassembly, one slot per internal byte
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_asm
            assign nxt_asm[8*gi+7:8*gi] =
                (extUpperEn && {30'h0, upIdx_ff} == gi) ? extRData[15:8] :
                (extLowerEn && {30'h0, loIdx_ff} == gi) ? extRData[7:0] :
                asm_ff[8*gi+7:8*gi];
        end
    endgenerate

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
            wide_ff <= 1'b0;
            little_ff <= 1'b0;
            write_ff <= 1'b0;
            size_ff <= `EBA_SIZE_BYTE;
            addr_ff <= 24'h000000;
            wdata_ff <= 32'h00000000;
            off_ff <= 2'h0;
            last_ff <= 1'b0;
            upIdx_ff <= 2'h0;
            loIdx_ff <= 2'h0;
            asm_ff <= 32'h00000000;
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspRData <= 32'h00000000;
            extValid <= 1'b0;
            extWrite <= 1'b0;
            extWord <= 1'b0;
            extAddr <= 24'h000000;
            extUpperEn <= 1'b0;
            extLowerEn <= 1'b0;
            extWData <= 16'h0000;
        end
        else
        begin
            rspValid <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    reqReady <= ~reqValid;
                    if (reqValid)
                    begin
                        state_ff <= ST_BUSY;
                        wide_ff <= mapWide;
                        little_ff <= mapLittle;
                        write_ff <= reqWrite;
                        size_ff <= reqSize;
                        addr_ff <= reqAddr;
                        wdata_ff <= reqWData;
                        asm_ff <= 32'h00000000;
                        extWrite <= reqWrite;
                    end
                end
                ST_BUSY:
                begin
                    reqReady <= 1'b0;
                    if (extReady)
                    begin
                        asm_ff <= nxt_asm;
                        if (last_ff)
                        begin
                            state_ff <= ST_IDLE;
                            reqReady <= 1'b1;
                            rspValid <= 1'b1;
                            rspRData <= write_ff ? 32'h00000000 : nxt_asm;
                        end
                    end
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                    reqReady <= 1'b1;
                end
            endcase
            if (take || (adv && !last_ff))
            begin
                extValid <= 1'b1;
                off_ff <= mapOff;
                last_ff <= mLast;
                upIdx_ff <= mUpIdx;
                loIdx_ff <= mLoIdx;
                extWord <= mWord;
                extUpperEn <= mUpEn;
                extLowerEn <= mLoEn;
                // Ascending byte addresses from the request address
                extAddr <= mapAddr + {22'h000000, mapOff};
                extWData[15:8] <= mUpEn ? mapWData[{mUpIdx, 3'h0} +: 8] : 8'h00;
                extWData[7:0] <= mLoEn ? mapWData[{mLoIdx, 3'h0} +: 8] : 8'h00;
            end
            else if (adv)
            begin
                extValid <= 1'b0;
                extUpperEn <= 1'b0;
                extLowerEn <= 1'b0;
                extWord <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ==== design/eba_lane_map.v ====
/*
 Lane planner for one external cycle: from area width, byte order,
 size, base address bit 0 and byte offset, gives the cycle size,
 which internal bytes ride which lane, and whether it is the last.
 Purely combinational; the caller registers everything it drives.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eba_regs.vh"

module eba_lane_map
(
    // Area attributes
    input wire wide,
    input wire little,
    // Request position
    input wire [1:0] size,
    input wire addr0,
    input wire [1:0] off,
    // Cycle plan
    output reg wordCyc,
    output reg [1:0] upIdx,
    output reg [1:0] loIdx,
    output reg upEn,
    output reg loEn,
    output reg last
);

    reg [1:0] nm1;
    reg [1:0] offNext;
    reg [1:0] idx0;
    reg [1:0] idx1;
    reg a0;

    always @*
    begin
        nm1 = {size[1], size[1] | size[0]};
        offNext = off + 2'h1;
        a0 = addr0 ^ off[0];
        // Byte at ascending offset j is b[j] little, b[n-1-j] big
        idx0 = little ? off : nm1 - off;
        idx1 = little ? offNext : nm1 - offNext;
        // Word cycle only at an even address with at least two bytes left
        wordCyc = wide & ~a0 & (off != nm1);
        upIdx = 2'h0;
        loIdx = 2'h0;
        upEn = 1'b0;
        loEn = 1'b0;
        if (!wide)
        begin
            loIdx = idx0;
            loEn = 1'b1;
        end
        else if (wordCyc)
        begin
            upEn = 1'b1;
            loEn = 1'b1;
            // Even address byte goes upper for big, lower for little
            upIdx = little ? idx1 : idx0;
            loIdx = little ? idx0 : idx1;
        end
        else if (little ? a0 : ~a0)
        begin
            upIdx = idx0;
            upEn = 1'b1;
        end
        else
        begin
            loIdx = idx0;
            loEn = 1'b1;
        end
        last = wordCyc ? (offNext == nm1) : (off == nm1);
    end

endmodule
`default_nettype wire

// ==== include/eba_regs.vh ====
/*
 Shared constants for the external bus endian aligner: request size
 codes, the area count and the default byte order of each area.
 Assumes inclusion by bare name from the design files.
*/
//
// Contract
// - Lane choice follows area width, access size and area byte order.
// - An 8-bit area moves one byte per cycle, on the lower lane only.
// - In an 8-bit area byte, word, longword take 1, 2, 4 cycles.
// - 8-bit big endian sends the most significant byte first.
// - 8-bit little endian sends the least significant byte first.
// - A 16-bit area uses both lanes, one byte or one word per cycle.
// - 16-bit big endian puts even bytes on upper, odd on lower lane.
// - 16-bit little endian puts even bytes on lower, odd on upper lane.
// - 16-bit big endian word: even is one cycle, odd is 15:8 then 7:0.
// - 16-bit big endian longword: even 31:16,15:0; odd 31:24,23:8,7:0.
// - 16-bit little endian word: even one cycle, odd 7:0 then 15:8.
// - 16-bit little endian longword: even 15:0,31:16; odd 7:0,23:8,31:24.
// - Byte order is chosen per area of the external space.
// - Bit n of the 8-bit order register is area n; 0 big, 1 little.
//
`ifndef EBA_REGS_VH
`define EBA_REGS_VH

// ****************************************
// Request size codes
// ****************************************
`define EBA_SIZE_BYTE 2'h0
`define EBA_SIZE_WORD 2'h1
`define EBA_SIZE_LONG 2'h2

// ****************************************
// Reset values and area count
// ****************************************
`define EBA_ORDER_RESET 8'h00
`define EBA_AREAS 8

`endif

// ==== tb/eba_aligner_properties.sv ====
/*
 Port checker for eba_aligner, bound to every instance.
 Assumes area settings stay steady while a request runs.
*/
`timescale 1ns/1ps
`default_nettype none
module eba_aligner_props
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Area settings and request
    input wire logic [7:0] areaWide16,
    input wire logic [7:0] areaLittleOrderSelect,
    input wire logic reqValid,
    input wire logic [1:0] reqSize,
    input wire logic [2:0] reqArea,
    input wire logic [23:0] reqAddr,
    input wire logic rspValid,
    // External cycle
    input wire logic extValid,
    input wire logic extReady,
    input wire logic extWord,
    input wire logic [23:0] extAddr,
    input wire logic extUpperEn,
    input wire logic extLowerEn
);
// ****************************************
// Request capture
// ****************************************
logic bF, wF, lF;
logic [1:0] sF;
logic [23:0] aF;
logic [2:0] cF, n8, n16;
assign n8 = sF == 2'h0 ? 3'h1 : (sF == 2'h1 ? 3'h2 : 3'h4);
assign n16 = (sF[1] ? 3'h2 : 3'h1) + {2'h0, aF[0] & (sF != 2'h0)};
always_ff @(posedge clk or negedge nrst)
    if (!nrst)
        {bF, wF, lF, sF, aF, cF} <= '0;
    else if (reqValid && (!bF || rspValid))
        {bF, wF, lF, sF, aF, cF} <= {1'b1, areaWide16[reqArea],
            areaLittleOrderSelect[reqArea], reqSize, reqAddr, 3'h0};
    else if (extValid && extReady)
        cF <= cF + 3'h1;
    else if (rspValid)
        bF <= 1'b0;
default clocking cb @(posedge clk); endclocking
default disable iff (!nrst);
property p_narrow;
    extValid && !wF |-> extLowerEn && !extUpperEn && !extWord;
endproperty
a_narrow: assert property (p_narrow) else $error("narrow lane");
property p_word;
    extValid && extWord |-> wF && extUpperEn && extLowerEn && !extAddr[0];
endproperty
a_word: assert property (p_word) else $error("word lanes");
property p_byte_be;
    extValid && wF && !lF && !extWord
        |-> {extUpperEn, extLowerEn} == {!extAddr[0], extAddr[0]};
endproperty
a_byte_be: assert property (p_byte_be) else $error("big lane");
property p_byte_le;
    extValid && wF && lF && !extWord
        |-> {extUpperEn, extLowerEn} == {extAddr[0], !extAddr[0]};
endproperty
a_byte_le: assert property (p_byte_le) else $error("little lane");
property p_first;
    $rose(extValid) |-> extAddr == aF;
endproperty
a_first: assert property (p_first) else $error("first address");
property p_ascend;
    extValid && extReady ##1 extValid
        |-> extAddr == $past(extAddr) + ($past(extWord) ? 24'h2 : 24'h1);
endproperty
a_ascend: assert property (p_ascend) else $error("address step");
property p_cnt8;
    rspValid && !wF |-> cF == n8;
endproperty
a_cnt8: assert property (p_cnt8) else $error("narrow count");
property p_cnt16;
    rspValid && wF |-> cF == n16;
endproperty
a_cnt16: assert property (p_cnt16) else $error("wide count");
c_narrow: cover property (rspValid && !wF && sF == 2'h2);
c_odd: cover property (rspValid && wF && aF[0] && sF == 2'h2);
c_le: cover property (extValid && lF && extWord);
endmodule
bind eba_aligner eba_aligner_props u_props (.clk(clk), .nrst(nrst),
    .areaWide16(areaWide16), .areaLittleOrderSelect(areaLittleOrderSelect),
    .reqValid(reqValid), .reqSize(reqSize), .reqArea(reqArea),
    .reqAddr(reqAddr), .rspValid(rspValid), .extValid(extValid),
    .extReady(extReady), .extWord(extWord), .extAddr(extAddr),
    .extUpperEn(extUpperEn), .extLowerEn(extLowerEn));
`default_nettype wire

// ==== tb/eba_ext_mem.sv ====
/*
 Behavioural external memory for the aligner's cycle port.
 Assumes the bench sets wide for the area of the current request.
*/
`timescale 1ns/1ps
`default_nettype none
module eba_ext_mem
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bench controls
    input wire logic wide,
    input wire logic [1:0] dly,
    // External cycle
    input wire logic extValid,
    input wire logic extWrite,
    input wire logic [23:0] extAddr,
    input wire logic extUpperEn,
    input wire logic extLowerEn,
    input wire logic [15:0] extWData,
    output logic extReady,
    output logic [15:0] extRData
);
// Low address bits only; each scenario reads back what it just wrote
logic [7:0] mem [0:1023];
logic [1:0] waitCnt;
logic [9:0] kU;
logic [9:0] kL;
// A 16-bit part shares one cell per lane between the two byte addresses
assign kU = wide ? {extAddr[9:1], 1'b1} : {extAddr[8:0], 1'b0};
assign kL = wide ? {extAddr[9:1], 1'b0} : {extAddr[8:0], 1'b0};
always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
        extReady <= 1'b0;
        extRData <= 16'h5AA5;
        waitCnt <= 2'h0;
    end
    else if (extValid && !extReady && waitCnt >= dly)
    begin
        extReady <= 1'b1;
        waitCnt <= 2'h0;
        // Idle lanes toggle so stale data never looks valid
        extRData[15:8] <= extUpperEn && !extWrite ? mem[kU] : ~extRData[15:8];
        extRData[7:0] <= extLowerEn && !extWrite ? mem[kL] : ~extRData[7:0];
        if (extWrite && extUpperEn)
            mem[kU] <= extWData[15:8];
        if (extWrite && extLowerEn)
            mem[kL] <= extWData[7:0];
    end
    else
    begin
        extReady <= 1'b0;
        waitCnt <= extValid && !extReady ? waitCnt + 2'h1 : 2'h0;
        extRData <= ~extRData;
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 Self-checking bench for eba_aligner against a memory model.
 Assumes the design, eba_ext_mem and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
logic clk = 1'b0, nrst = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
logic memWide = 1'b0;
logic [1:0] reqSize = 2'h0, dly = 2'h0;
logic [2:0] reqArea = 3'h0;
logic [23:0] reqAddr = 24'h0;
logic [31:0] reqWData = 32'h0;
// Areas 2 and 3 wide; areas 1 and 3 little order
logic [7:0] areaWide16 = 8'h0C, areaLittleOrderSelect = 8'h0A;
wire reqReady, rspValid, extValid, extReady, extWrite, extWord;
wire extUpperEn, extLowerEn;
wire [31:0] rspRData;
wire [23:0] extAddr;
wire [15:0] extWData, extRData;
int errors = 0, checks = 0, cycles = 0;
always #2 clk = ~clk;
eba_aligner u_dut (.clk(clk), .nrst(nrst), .areaWide16(areaWide16),
    .areaLittleOrderSelect(areaLittleOrderSelect), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqSize(reqSize),
    .reqArea(reqArea), .reqAddr(reqAddr), .reqWData(reqWData),
    .rspValid(rspValid), .rspRData(rspRData), .extValid(extValid),
    .extReady(extReady), .extWrite(extWrite), .extWord(extWord),
    .extAddr(extAddr), .extUpperEn(extUpperEn), .extLowerEn(extLowerEn),
    .extWData(extWData), .extRData(extRData));
eba_ext_mem u_mem (.clk(clk), .nrst(nrst), .wide(memWide), .dly(dly),
    .extValid(extValid), .extWrite(extWrite), .extAddr(extAddr),
    .extUpperEn(extUpperEn), .extLowerEn(extLowerEn),
    .extWData(extWData), .extReady(extReady), .extRData(extRData));
// ****************************************
// Shared tasks
// ****************************************
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
        errors++;
        $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
endtask
task automatic stop_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
always @(posedge clk)
begin
    cycles++;
    if (cycles == 20000)
    begin
        errors++;
        stop_test();
    end
end
task automatic req(input logic w, input logic [1:0] sz, input logic [2:0] ar,
    input logic [23:0] ad, input logic [31:0] d);
    int n, j, e, c;
    logic [23:0] a;
    logic [31:0] k;
    logic [9:0] m;
    logic [7:0] b;
    logic le, wd;
    n = 1 << sz;
    le = areaLittleOrderSelect[ar];
    wd = areaWide16[ar];
    e = 0;
    for (j = 0; j < n; e++)
        j += (wd && !(ad[0] ^ j[0]) && j + 2 <= n) ? 2 : 1;
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqSize <= sz;
    reqArea <= ar;
    reqAddr <= ad;
    reqWData <= d;
    memWide <= wd;
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    c = 0;
    do
    begin
        @(posedge clk);
        if (extValid === 1'b1 && extReady === 1'b1)
            c++;
    end
    while (rspValid !== 1'b1);
    check(c, e);
    k = n == 4 ? d : d & ((32'h1 << (8 * n)) - 32'h1);
    check(rspRData, w ? 32'h0 : k);
    for (j = 0; w && j < n; j++)
    begin
        a = ad + j;
        m = wd ? {a[9:1], a[0] ^ ~le} : {a[8:0], 1'b0};
        b = le ? d[8 * j +: 8] : d[8 * (n - 1 - j) +: 8];
        check(u_mem.mem[m], b);
    end
endtask
task automatic wr_rd(input logic [1:0] sz, input logic [2:0] ar,
    input logic [23:0] ad);
    req(1'b1, sz, ar, ad, 32'hA4B3C2D1 ^ {30'h0, sz});
    req(1'b0, sz, ar, ad, 32'hA4B3C2D1 ^ {30'h0, sz});
endtask
// ****************************************
// Scenarios
// ****************************************
task automatic t_narrow;
    dly <= 2'h0;
    for (int s = 0; s < 3; s++)
    begin
        wr_rd(s[1:0], 3'h0, 24'h000101);
        wr_rd(s[1:0], 3'h1, 24'h100100);
    end
endtask
task automatic t_wide_even;
    dly <= 2'h2;
    for (int s = 0; s < 3; s++)
    begin
        wr_rd(s[1:0], 3'h2, 24'h200000);
        wr_rd(s[1:0], 3'h3, 24'h300004);
    end
endtask
task automatic t_wide_odd;
    dly <= 2'h1;
    for (int s = 0; s < 3; s++)
    begin
        wr_rd(s[1:0], 3'h2, 24'h200011);
        wr_rd(s[1:0], 3'h3, 24'h300013);
    end
endtask
task automatic t_order;
    // Order flop needs a cycle before the next request
    areaLittleOrderSelect <= 8'h8A;
    repeat (2) @(posedge clk);
    wr_rd(2'h2, 3'h7, 24'h700003);
    wr_rd(2'h1, 3'h7, 24'h700010);
endtask
initial
begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_narrow();
    t_wide_even();
    t_wide_odd();
    t_order();
    stop_test();
end
endmodule
`default_nettype wire
